// file: logic/or_slice_pkg.sv
// Shared constants and carriers for the OR execution slice of one core.
// Assumes a single 40 MHz system clock and a synchronous active-high reset.
`default_nettype none

package or_slice_pkg;

   // -------------------------------------------------------------------------
   // Widths.
   // -------------------------------------------------------------------------
   localparam int unsigned WORD_W = 32;
   localparam int unsigned ADDR_W = 9;
   localparam int unsigned LIT_W = 9;
   localparam int unsigned PAR_LO = 2;
   localparam int unsigned PAR_HI = 15;

   // -------------------------------------------------------------------------
   // Local memory map (long-word locations).
   // -------------------------------------------------------------------------
   localparam logic [ADDR_W-1:0] CODE_FIRST = 9'h000;
   localparam logic [ADDR_W-1:0] CODE_LAST = 9'h1ef;
   localparam logic [ADDR_W-1:0] LAUNCH_PARAMETER_ADDR = 9'h1f0;
   localparam logic [ADDR_W-1:0] PIN_OUTPUT_LATCH_ADDR = 9'h1f4;
   localparam logic [ADDR_W-1:0] SECOND_PORT_OUTPUT_LATCH_ADDR = 9'h1f5;
   localparam int unsigned MEM_DEPTH = 512;

   // -------------------------------------------------------------------------
   // Reset values.
   // -------------------------------------------------------------------------
   localparam logic [WORD_W-1:0] LATCH_RESET = 32'h0000_0000;
   localparam logic [WORD_W-1:0] PARAM_RESET = 32'h0000_0000;

   // -------------------------------------------------------------------------
   // Operations the slice executes.
   // -------------------------------------------------------------------------
   typedef enum logic [1:0] {
      OP_OR,
      OP_MOVE,
      OP_INSERT_C
   } op_type;

   // One issued instruction from the core pipeline.
   typedef struct packed {
      op_type op;
      logic [ADDR_W-1:0] dest;
      logic [LIT_W-1:0] src;
      logic src_is_literal;
      logic zero_flag_write_effect;
      logic carry_flag_write_effect;
      logic no_result_write_effect;
   } instr_type;

   // One start request from the launching core.
   typedef struct packed {
      logic core_start_command;
      logic core_new_start_command;
      logic [WORD_W-1:0] parameter_value;
   } launch_type;

endpackage

`default_nettype wire

// file: logic/or_slice.sv
// Execution slice of one core: OR, move and masked insert, flag effects,
// pin output latch, launch parameter register and code image loading.
// Assumes the pipeline issues one instruction per cycle from this clock,
// and the launching core streams image longs after a start request.
`timescale 1ns/1ps
`default_nettype none

module or_slice (
   // Clock and reset.
   input wire logic sys_clk_in,
   input wire logic rst_in,
   // Instruction issue from the core pipeline.
   input wire logic instr_valid_in,
   input wire or_slice_pkg::instr_type instr_in,
   // Launch request and image stream from the launching core.
   input wire or_slice_pkg::launch_type launch_in,
   input wire logic image_valid_in,
   input wire logic image_last_in,
   input wire logic [31:0] image_data_in,
   // Pin direction from the core's direction register.
   input wire logic [31:0] pin_dir_in,
   // Pins and status.
   output logic [31:0] pin_level_out,
   output logic [31:0] pin_oe_out,
   output logic zero_flag_out,
   output logic carry_flag_out,
   output logic loading_out
);

   // -------------------------------------------------------------------------
   // State.
   // -------------------------------------------------------------------------
   logic [31:0] mem [or_slice_pkg::MEM_DEPTH];
   logic [31:0] latch_reg, latch_next;
   logic [31:0] param_reg, param_next;
   logic [31:0] pin_oe_reg, pin_oe_next;
   logic zero_reg, zero_next;
   logic carry_reg, carry_next;
   logic loading_reg, loading_next;
   logic [8:0] load_ptr_reg, load_ptr_next;

   // Datapath signals.
   logic exec;
   logic start;
   logic [31:0] dest_val;
   logic [31:0] src_val;
   logic [31:0] result;
   logic wr_en;
   logic mem_wr;
   logic [8:0] mem_wr_addr;
   logic [31:0] mem_wr_data;

   // -------------------------------------------------------------------------
   // Operand fetch.
   // -------------------------------------------------------------------------
   // Instructions are refused while an image is streaming in, so the
   // memory has only one writer per cycle.
   assign exec = instr_valid_in && !loading_reg;
   assign start = launch_in.core_start_command || launch_in.core_new_start_command;

   // The destination read of the parameter address falls through to the
   // shadow location; only the source path sees the launch value.
   always_comb begin
      if (instr_in.dest == or_slice_pkg::PIN_OUTPUT_LATCH_ADDR) begin
         dest_val = latch_reg;
      end else begin
         dest_val = mem[instr_in.dest];
      end
   end

   // Source is either a zero-extended literal or a register read.
   always_comb begin
      if (instr_in.src_is_literal) begin
         src_val = {23'h00_0000, instr_in.src};
      end else if (instr_in.src == or_slice_pkg::LAUNCH_PARAMETER_ADDR) begin
         src_val = param_reg;
      end else if (instr_in.src == or_slice_pkg::PIN_OUTPUT_LATCH_ADDR) begin
         src_val = latch_reg;
      end else begin
         src_val = mem[instr_in.src];
      end
   end

   // -------------------------------------------------------------------------
   // Execute.
   // -------------------------------------------------------------------------
   // The masked insert and the OR change only source-selected bits; the move replaces the word.
   always_comb begin
      unique case (instr_in.op)
         or_slice_pkg::OP_OR: result = dest_val | src_val;
         or_slice_pkg::OP_MOVE: result = src_val;
         or_slice_pkg::OP_INSERT_C: begin
            result = (dest_val & ~src_val) | (carry_reg ? src_val : 32'h0000_0000);
         end
         // The fourth code is never issued; a plain OR keeps the result defined.
         default: result = dest_val | src_val;
      endcase
   end

   assign wr_en = exec && !instr_in.no_result_write_effect;

   // -------------------------------------------------------------------------
   // Flags, latch, parameter and loader next state.
   // -------------------------------------------------------------------------
   // A start request mid-load restarts the image at location zero.
   always_comb begin
      zero_next = zero_reg;
      carry_next = carry_reg;
      latch_next = latch_reg;
      param_next = param_reg;
      loading_next = loading_reg;
      load_ptr_next = load_ptr_reg;
      pin_oe_next = pin_dir_in;
      if (exec && instr_in.zero_flag_write_effect) begin
         zero_next = (result == 32'h0000_0000);
      end
      if (exec && instr_in.carry_flag_write_effect) begin
         carry_next = ^result;
      end
      if (wr_en && instr_in.dest == or_slice_pkg::PIN_OUTPUT_LATCH_ADDR) begin
         latch_next = result;
      end
      if (start) begin
         param_next = {16'h0000,
            launch_in.parameter_value[or_slice_pkg::PAR_HI:or_slice_pkg::PAR_LO],
            2'b00};
         loading_next = 1'b1;
         load_ptr_next = or_slice_pkg::CODE_FIRST;
      end else if (loading_reg && image_valid_in) begin
         if (image_last_in || load_ptr_reg == or_slice_pkg::CODE_LAST) begin
            loading_next = 1'b0;
         end else begin
            load_ptr_next = load_ptr_reg + 9'h001;
         end
      end
   end

   // Memory write port: the loader owns it while loading.
   always_comb begin
      mem_wr = 1'b0;
      mem_wr_addr = instr_in.dest;
      mem_wr_data = result;
      if (loading_reg && !start) begin
         mem_wr = image_valid_in;
         mem_wr_addr = load_ptr_reg;
         mem_wr_data = image_data_in;
      end else if (wr_en && instr_in.dest != or_slice_pkg::PIN_OUTPUT_LATCH_ADDR) begin
         // The second-port latch is plain storage with no pin attached.
         mem_wr = 1'b1;
      end
   end

   // -------------------------------------------------------------------------
   // Registers.
   // -------------------------------------------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         zero_reg <= 1'b0;
         carry_reg <= 1'b0;
         latch_reg <= or_slice_pkg::LATCH_RESET;
         param_reg <= or_slice_pkg::PARAM_RESET;
         pin_oe_reg <= 32'h0000_0000;
         loading_reg <= 1'b0;
         load_ptr_reg <= or_slice_pkg::CODE_FIRST;
      end else begin
         zero_reg <= zero_next;
         carry_reg <= carry_next;
         latch_reg <= latch_next;
         param_reg <= param_next;
         pin_oe_reg <= pin_oe_next;
         loading_reg <= loading_next;
         load_ptr_reg <= load_ptr_next;
      end
   end

   // Local memory is not reset; software never relies on its power-up contents.
   always_ff @(posedge sys_clk_in) begin
      if (mem_wr) begin
         mem[mem_wr_addr] <= mem_wr_data;
      end
   end

   // Outputs come straight from flops; the pin level is the latch itself.
   assign pin_level_out = latch_reg;
   assign pin_oe_out = pin_oe_reg;
   assign zero_flag_out = zero_reg;
   assign carry_flag_out = carry_reg;
   assign loading_out = loading_reg;

   // -------------------------------------------------------------------------
   // Assertions.
   // -------------------------------------------------------------------------
   logic to_latch;
   assign to_latch = exec && instr_in.dest == or_slice_pkg::PIN_OUTPUT_LATCH_ADDR;

   sequence seq_start;
      start;
   endsequence

   sequence seq_first_long;
      loading_reg && !start && image_valid_in;
   endsequence

   a_or_to_latch: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      to_latch && !instr_in.no_result_write_effect && instr_in.op == or_slice_pkg::OP_OR
      |=> latch_reg == ($past(dest_val) | $past(src_val)))
      else $error("OR result did not reach the pin latch");

   a_zero_flag: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      exec && instr_in.zero_flag_write_effect |=> zero_reg == ($past(result) == 32'h0000_0000))
      else $error("zero flag does not match result");

   a_carry_parity: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      exec && instr_in.carry_flag_write_effect |=> carry_reg == ^$past(result))
      else $error("carry flag is not result parity");

   a_no_result_hold: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      to_latch && instr_in.no_result_write_effect |=> $stable(latch_reg))
      else $error("latch changed under no-result effect");

   a_load_from_zero: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      seq_start ##1 seq_first_long |-> load_ptr_reg == or_slice_pkg::CODE_FIRST && mem_wr)
      else $error("image did not start at location zero");

   a_load_bound: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      loading_reg |-> load_ptr_reg <= or_slice_pkg::CODE_LAST)
      else $error("loader ran past code space");

   a_param_capture: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      seq_start |=> param_reg == {16'h0000, $past(launch_in.parameter_value[15:2]), 2'b00})
      else $error("launch parameter not aligned capture");

   a_param_read_only: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      !start |=> $stable(param_reg))
      else $error("launch parameter changed outside launch");

   a_param_shadow: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      wr_en && instr_in.dest == or_slice_pkg::LAUNCH_PARAMETER_ADDR |-> mem_wr)
      else $error("parameter destination skipped shadow write");

   a_no_stall: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      instr_valid_in && !loading_reg && !start |=> !loading_reg)
      else $error("instruction stalled the slice");

endmodule

`default_nettype wire

// file: verification/launch_model.sv
// Behavioural model of the core that launches this core: one start, then an image stream.
// Assumes the bench holds go_in until busy_out rises; everything changes on falling edges.
`timescale 1ns/1ps
`default_nettype none
module launch_model (
   // Clock and requests from the bench.
   input wire logic clk_in,
   input wire logic go_in,
   input wire logic use_new_in,
   input wire logic slow_in,
   input wire logic [31:0] param_in,
   input wire logic [3:0] count_in,
   input wire logic [31:0] img_in [8],
   // Start and image stream towards the core.
   output or_slice_pkg::launch_type launch_out,
   output logic image_valid_out,
   output logic image_last_out,
   output logic [31:0] image_data_out,
   output logic busy_out
);
   // --------------------------------------------------------------------------
   // Launch sequence
   // --------------------------------------------------------------------------
   // Idle data shows the inverse of the last long, so a stale value never passes as fresh.
   initial begin
      launch_out = '0;
      image_valid_out = 1'b0;
      image_last_out = 1'b0;
      image_data_out = 32'h0000_0000;
      busy_out = 1'b0;
      forever begin
         @(negedge clk_in iff go_in);
         busy_out = 1'b1;
         launch_out = '{!use_new_in, use_new_in, param_in};
         @(negedge clk_in);
         launch_out = '0;
         for (int i = 0; i < count_in; i++) begin
            if (slow_in) @(negedge clk_in);
            image_valid_out = 1'b1;
            image_data_out = img_in[i];
            image_last_out = (i == count_in - 1);
            @(negedge clk_in);
            image_valid_out = 1'b0;
            image_last_out = 1'b0;
            image_data_out = ~image_data_out;
         end
         busy_out = 1'b0;
      end
   end
endmodule
`default_nettype wire

// file: verification/tb_or_slice.sv
// Self-checking bench for the OR slice: random OR traffic plus corner cases.
// Assumes the launch model in its own file; inputs change on falling edges.
`timescale 1ns/1ps
`default_nettype none
module tb_or_slice;
   localparam logic [8:0] PIN = or_slice_pkg::PIN_OUTPUT_LATCH_ADDR;
   localparam logic [8:0] PAR = or_slice_pkg::LAUNCH_PARAMETER_ADDR;
   logic sys_clk_in, rst_in, instr_valid_in, go, use_new, slow, busy, lit, zf, cf;
   logic image_valid_in, image_last_in, zero_flag_out, carry_flag_out, loading_out;
   or_slice_pkg::instr_type instr_in;
   or_slice_pkg::launch_type launch_in;
   logic [31:0] image_data_in, pin_dir_in, pin_level_out, pin_oe_out, param, lat, sv, m;
   logic [31:0] img [8];
   logic [8:0] s;
   logic [3:0] cnt;
   int errors, n_checks;

   or_slice DUT (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .instr_valid_in(instr_valid_in),
      .instr_in(instr_in), .launch_in(launch_in), .image_valid_in(image_valid_in),
      .image_last_in(image_last_in), .image_data_in(image_data_in), .pin_dir_in(pin_dir_in),
      .pin_level_out(pin_level_out), .pin_oe_out(pin_oe_out), .zero_flag_out(zero_flag_out),
      .carry_flag_out(carry_flag_out), .loading_out(loading_out));
   launch_model partner (.clk_in(sys_clk_in), .go_in(go), .use_new_in(use_new), .slow_in(slow),
      .param_in(param), .count_in(cnt), .img_in(img), .launch_out(launch_in),
      .image_valid_out(image_valid_in), .image_last_out(image_last_in),
      .image_data_out(image_data_in), .busy_out(busy));

   // --------------------------------------------------------------------------
   // Shared tasks
   // --------------------------------------------------------------------------
   task automatic check(string what, logic [31:0] e, logic [31:0] v);
      n_checks++;
      if (v !== e) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, v);
      end
   endtask

   // Expected launch value: bits 2 to 15 kept, the rest cleared.
   function automatic logic [31:0] exp_param(logic [31:0] p);
      return {16'h0000, p[15:2], 2'b00};
   endfunction

   // Expected masked insert: mask bits take the carry, the rest keep the latch.
   function automatic logic [31:0] exp_insert(logic [31:0] d, logic [31:0] mk, logic c);
      return (d & ~mk) | (c ? mk : 32'h0000_0000);
   endfunction

   // One instruction, valid for exactly one rising edge; its effect shows at the next fall.
   task automatic issue(or_slice_pkg::op_type op, logic [8:0] d, logic [8:0] sr, logic l,
         logic wz, logic wc, logic nr);
      @(negedge sys_clk_in);
      instr_in = '{op, d, sr, l, wz, wc, nr};
      instr_valid_in = 1'b1;
      @(negedge sys_clk_in);
      instr_valid_in = 1'b0;
   endtask

   task automatic mov(logic [8:0] sr, logic l, logic [31:0] v);
      issue(or_slice_pkg::OP_MOVE, PIN, sr, l, 1'b0, 1'b0, 1'b0);
      lat = v;
      check("latch after move", lat, pin_level_out);
   endtask

   // Flags move only when their effect is selected; the model keeps them otherwise.
   task automatic or_op(logic [8:0] sr, logic l, logic wz, logic wc, logic nr, logic [31:0] v);
      issue(or_slice_pkg::OP_OR, PIN, sr, l, wz, wc, nr);
      if (wz) zf = ((lat | v) == 32'h0000_0000);
      if (wc) cf = ^(lat | v);
      if (!nr) lat = lat | v;
      check("or result", lat, pin_level_out);
      check("zero flag", {31'h0, zf}, {31'h0, zero_flag_out});
      check("carry flag", {31'h0, cf}, {31'h0, carry_flag_out});
   endtask

   task automatic launch(logic nw, logic sl, logic [3:0] n);
      int k;
      for (k = 0; k < 8; k++) img[k] = $urandom;
      param = $urandom | 32'h0000_0004;
      use_new = nw;
      slow = sl;
      cnt = n;
      go = 1'b1;
      for (k = 0; k < 20 && !busy; k++) @(negedge sys_clk_in);
      check("partner started", 32'h1, {31'h0, busy});
      go = 1'b0;
      for (k = 0; k < 100 && busy; k++) @(negedge sys_clk_in);
      check("partner finished", 32'h0, {31'h0, busy});
      @(negedge sys_clk_in);
      check("loading", 32'h0, {31'h0, loading_out});
      for (k = 0; k < n; k++) mov(k[8:0], 1'b0, img[k]);
      mov(PAR, 1'b0, exp_param(param));
   endtask

   task automatic test_done;
      if (errors == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // --------------------------------------------------------------------------
   // Clock, watchdog and main sequence
   // --------------------------------------------------------------------------
   initial begin
      sys_clk_in = 1'b0;
      forever #12.5 sys_clk_in = ~sys_clk_in;
   end

   // The whole run needs well under 2000 cycles; a hang is cut off long after.
   initial begin
      repeat (20000) @(posedge sys_clk_in);
      errors++;
      test_done();
   end

   initial begin
      errors = 0;
      n_checks = 0;
      rst_in = 1'b1;
      instr_valid_in = 1'b0;
      instr_in = '0;
      {go, use_new, slow, zf, cf} = 5'h00;
      {cnt, param, pin_dir_in, lat} = '0;
      for (int i = 0; i < 8; i++) img[i] = 32'h0000_0000;
      void'($urandom(33));
      repeat (2) @(negedge sys_clk_in);
      rst_in = 1'b0;
      check("reset latch", 32'h0, pin_level_out);
      check("reset status", 32'h0,
         {28'h0, zero_flag_out, carry_flag_out, loading_out, pin_oe_out[0]});
      check("reset enables", 32'h0, pin_oe_out);
      launch(1'b0, 1'b1, 4'h8);
      repeat (40) begin
         pin_dir_in = $urandom;
         s = 9'($urandom % 8);
         mov(s, 1'b0, img[s]);
         check("pin enable", pin_dir_in, pin_oe_out);
         lit = 1'($urandom);
         s = lit ? 9'($urandom) : 9'($urandom % 8);
         sv = lit ? {23'h0, s} : img[s];
         or_op(s, lit, 1'($urandom), 1'($urandom), 1'($urandom), sv);
         m = {23'h0, 9'($urandom)};
         issue(or_slice_pkg::OP_INSERT_C, PIN, m[8:0], 1'b1, 1'b0, 1'b0, 1'b0);
         lat = exp_insert(lat, m, cf);
         check("masked insert", lat, pin_level_out);
      end
      // Truth-table corners: all zero, a single one, and ten or five.
      mov(9'h000, 1'b1, 32'h0);
      or_op(9'h000, 1'b1, 1'b1, 1'b1, 1'b0, 32'h0);
      or_op(9'h001, 1'b1, 1'b1, 1'b1, 1'b0, 32'h1);
      mov(9'h00a, 1'b1, 32'ha);
      or_op(9'h005, 1'b1, 1'b1, 1'b1, 1'b0, 32'h5);
      issue(or_slice_pkg::OP_MOVE, or_slice_pkg::SECOND_PORT_OUTPUT_LATCH_ADDR, 9'h1ab, 1'b1,
         1'b0, 1'b0, 1'b0);
      check("pins after second port write", lat, pin_level_out);
      mov(or_slice_pkg::SECOND_PORT_OUTPUT_LATCH_ADDR, 1'b0, 32'h1ab);
      // Writing the parameter address reaches only the shadow word beneath it.
      issue(or_slice_pkg::OP_MOVE, PAR, 9'h000, 1'b1, 1'b0, 1'b0, 1'b0);
      issue(or_slice_pkg::OP_OR, PAR, 9'h000, 1'b1, 1'b1, 1'b0, 1'b0);
      check("shadow zero flag", 32'h1, {31'h0, zero_flag_out});
      mov(PAR, 1'b0, exp_param(param));
      launch(1'b1, 1'b0, 4'h3);
      test_done();
   end
endmodule
`default_nettype wire
